// [wdog_pkg.sv]
// Contract
// - with count_run set, the counter advances once per selected prescaler pulse
// - wrap from ff to 00 sets the overflow flag
// - counter zero at reset, held at zero while count_run is 0
// - software clears the overflow flag only by read-while-set then write 0
// - mode select: 0 requests interval interrupt, 1 generates watchdog reset
// - interval mode raises an interrupt request at every overflow
// - watchdog reset resets chip internally, optionally drives reset_out_n low
// - divide codes 0..7 select clock/2,32,64,128,256,512,2048,4096
// - control/status bits 4 and 3 ignore writes and read as 1
// - flag, mode and run bits clear on reset and on standby entry
// - divide bits clear on reset but hold through software standby
// - word writes at ffa8 and ffaa, byte reads at ffa8 (shared with the write), ffa9 and ffab
// - bit 7 of both status registers accepts only a written 0
// - high byte 5a loads counter, a5 loads control/status, else nothing
// - a5 with low 00 clears reset flag; 5a loads reset output enable
// - internal reset held 518 states, external output low 132 states
// - reset flag set on watchdog reset, cleared only by pin or software
package wdog_pkg;
  localparam logic [15:0] WR_ADDR_TCS = 16'hffa8;
  localparam logic [15:0] WR_ADDR_RCS = 16'hffaa;
  localparam logic [15:0] RD_ADDR_TCS = 16'hffa8;
  localparam logic [15:0] RD_ADDR_CNT = 16'hffa9;
  localparam logic [15:0] RD_ADDR_RCS = 16'hffab;
  localparam logic [7:0] PW_COUNTER = 8'h5a;
  localparam logic [7:0] PW_CONTROL = 8'ha5;
  localparam logic [7:0] TCS_RESET = 8'h18;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] RCS_RESET = 8'h3f;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam int FLAG_BIT = 7;
  localparam int MODE_BIT = 6;
  localparam int RUN_BIT = 5;
  localparam int RFLAG_BIT = 7;
  localparam int OUT_EN_BIT = 6;
  localparam logic [7:0] TCS_RSVD_ONES = 8'h18;
  localparam logic [7:0] RCS_RSVD_ONES = 8'h3f;
  localparam int PRESC_W = 12;
  localparam int INT_RESET_STATES = 518;
  localparam int EXT_RESET_STATES = 132;
  localparam int RST_CNT_W = 10;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic overflow_flag;
    logic timer_mode_sel;
    logic count_run;
    logic [2:0] clk_div_sel;
  } tcs_fields_s;
endpackage : wdog_pkg

// [wdog_prescaler.sv]
`timescale 1ns/1ps
module wdog_prescaler
  import wdog_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  logic [PRESC_W-1:0] div_ff;
  logic [PRESC_W-1:0] nxt_div;
  logic [PRESC_W-1:0] mask;

  assign nxt_div = div_ff + 12'h001;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  always_comb begin
    case (sel_i)
      3'h0: mask = 12'h001;
      3'h1: mask = 12'h01f;
      3'h2: mask = 12'h03f;
      3'h3: mask = 12'h07f;
      3'h4: mask = 12'h0ff;
      3'h5: mask = 12'h1ff;
      3'h6: mask = 12'h7ff;
      default: mask = 12'hfff;
    endcase
  end

  assign tick_o = ((div_ff & mask) == mask);
endmodule : wdog_prescaler

// [wdog_reset_pulse.sv]
`timescale 1ns/1ps
module wdog_reset_pulse
  import wdog_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic out_en_i,
  output logic int_rst_o,
  output logic ext_rst_n_o
);
  localparam logic [RST_CNT_W-1:0] INT_N = RST_CNT_W'(INT_RESET_STATES);
  localparam logic [RST_CNT_W-1:0] EXT_N = RST_CNT_W'(EXT_RESET_STATES);
  logic [RST_CNT_W-1:0] cnt_ff;
  logic ext_ff;
  logic [RST_CNT_W-1:0] hold_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (start_i && cnt_ff == '0) begin
      cnt_ff <= INT_N;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 10'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_ff <= 1'b0;
    end else if (start_i && cnt_ff == '0) begin
      ext_ff <= out_en_i;
    end else if (cnt_ff == INT_N - EXT_N + 10'h001) begin
      ext_ff <= 1'b0;
    end
  end

  // length of the running internal reset, for checking only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_ff <= '0;
    end else if (int_rst_o) begin
      hold_ff <= hold_ff + 10'h001;
    end else begin
      hold_ff <= '0;
    end
  end

  assign int_rst_o = (cnt_ff != '0);
  assign ext_rst_n_o = ~ext_ff;

  a_int_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(int_rst_o) |-> int_rst_o [*8])
    else $error("internal reset too short");
  a_ext_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(ext_rst_n_o) |-> ##(EXT_RESET_STATES) ext_rst_n_o && !$past(ext_rst_n_o))
    else $error("external reset length wrong");
  a_int_total: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(int_rst_o) |-> hold_ff == INT_N)
    else $error("internal reset length wrong");
  a_ext_inside: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ext_rst_n_o |-> int_rst_o)
    else $error("external reset outside internal reset");
endmodule : wdog_reset_pulse

// [wdog_unit.sv]
`timescale 1ns/1ps
module wdog_unit
  import wdog_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic STANDBY_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic INTERVAL_IRQ_O,
  output logic CHIP_RESET_O,
  output logic RESET_OUT_N_O
);
  bus_req_s req;
  tcs_fields_s tcs_ff;
  logic [7:0] wdog_counter_ff;
  logic wdog_reset_flag_ff;
  logic reset_out_en_ff;
  logic flag_armed_ff;
  logic rflag_armed_ff;
  logic [7:0] rdata_ff;
  logic tick;
  logic step;
  logic overflow;
  logic wr_cnt;
  logic wr_tcs;
  logic wr_rcs_clr;
  logic wr_rcs_oe;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] tcs_rd;
  logic [7:0] rcs_rd;
  logic int_rst;
  logic wd_start;

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign lo = req.wdata[7:0];
  assign hi = req.wdata[15:8];

  wdog_prescaler u_presc (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .sel_i(tcs_ff.clk_div_sel),
    .tick_o(tick)
  );

  // word-write decode
  always_comb begin
    wr_cnt = 1'b0;
    wr_tcs = 1'b0;
    wr_rcs_clr = 1'b0;
    wr_rcs_oe = 1'b0;
    if (req.wr && req.addr == WR_ADDR_TCS) begin
      wr_cnt = (hi == PW_COUNTER);
      wr_tcs = (hi == PW_CONTROL);
    end else if (req.wr && req.addr == WR_ADDR_RCS) begin
      wr_rcs_clr = (hi == PW_CONTROL) && (lo == 8'h00);
      wr_rcs_oe = (hi == PW_COUNTER);
    end
  end

  assign step = tcs_ff.count_run && tick && !int_rst;
  assign overflow = step && (wdog_counter_ff == CNT_MAX);
  assign wd_start = overflow && tcs_ff.timer_mode_sel;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wdog_counter_ff <= CNT_RESET;
    end else if (!tcs_ff.count_run || int_rst || STANDBY_I) begin
      wdog_counter_ff <= CNT_RESET;
    end else if (wr_cnt) begin
      wdog_counter_ff <= lo;
    end else if (step) begin
      wdog_counter_ff <= wdog_counter_ff + 8'h01;
    end
  end

  // read-then-clear arming for the overflow flag
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flag_armed_ff <= 1'b0;
    end else if (overflow) begin
      flag_armed_ff <= 1'b0;
    end else if (req.rd && req.addr == RD_ADDR_TCS && tcs_ff.overflow_flag) begin
      flag_armed_ff <= 1'b1;
    end else if (wr_tcs || !tcs_ff.overflow_flag) begin
      flag_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tcs_ff <= '0;
    end else if (STANDBY_I || int_rst) begin
      tcs_ff.overflow_flag <= 1'b0;
      tcs_ff.timer_mode_sel <= 1'b0;
      tcs_ff.count_run <= 1'b0;
      if (int_rst) begin
        tcs_ff.clk_div_sel <= '0;
      end
    end else begin
      if (overflow) begin
        tcs_ff.overflow_flag <= 1'b1;
      end else if (wr_tcs && !lo[FLAG_BIT] && flag_armed_ff) begin
        tcs_ff.overflow_flag <= 1'b0;
      end
      if (wr_tcs) begin
        tcs_ff.timer_mode_sel <= lo[MODE_BIT];
        tcs_ff.count_run <= lo[RUN_BIT];
        tcs_ff.clk_div_sel <= lo[2:0];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rflag_armed_ff <= 1'b0;
    end else if (req.rd && req.addr == RD_ADDR_RCS && wdog_reset_flag_ff) begin
      rflag_armed_ff <= 1'b1;
    end else if (wr_rcs_clr || !wdog_reset_flag_ff) begin
      rflag_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wdog_reset_flag_ff <= 1'b0;
    end else if (wd_start) begin
      wdog_reset_flag_ff <= 1'b1;
    end else if (wr_rcs_clr && rflag_armed_ff) begin
      wdog_reset_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      reset_out_en_ff <= 1'b0;
    end else if (wr_rcs_oe) begin
      reset_out_en_ff <= lo[OUT_EN_BIT];
    end
  end

  wdog_reset_pulse u_rst (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .start_i(wd_start),
    .out_en_i(reset_out_en_ff),
    .int_rst_o(int_rst),
    .ext_rst_n_o(RESET_OUT_N_O)
  );

  assign tcs_rd = {tcs_ff.overflow_flag, tcs_ff.timer_mode_sel, tcs_ff.count_run,
                   2'b00, tcs_ff.clk_div_sel} | TCS_RSVD_ONES;
  assign rcs_rd = {wdog_reset_flag_ff, reset_out_en_ff, 6'h00} | RCS_RSVD_ONES;

  // byte reads
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == RD_ADDR_TCS) begin
        rdata_ff <= tcs_rd;
      end else if (req.addr == RD_ADDR_CNT) begin
        rdata_ff <= wdog_counter_ff;
      end else if (req.addr == RD_ADDR_RCS) begin
        rdata_ff <= rcs_rd;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign RDATA_O = rdata_ff;
  assign INTERVAL_IRQ_O = overflow && !tcs_ff.timer_mode_sel;
  assign CHIP_RESET_O = int_rst;

  a_flag_sets: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    overflow && !STANDBY_I |=> tcs_ff.overflow_flag)
    else $error("overflow did not set flag");
  a_cnt_stopped: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !tcs_ff.count_run |=> wdog_counter_ff == CNT_RESET || $past(wr_tcs))
    else $error("counter not held at zero");
  a_no_blind_clr: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    tcs_ff.overflow_flag && !flag_armed_ff && !STANDBY_I && !int_rst
    |=> tcs_ff.overflow_flag)
    else $error("flag cleared without read");
  a_irq_mode: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    INTERVAL_IRQ_O |-> !tcs_ff.timer_mode_sel && !wd_start)
    else $error("interrupt in watchdog mode");
  a_wd_reset: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wd_start |=> CHIP_RESET_O && wdog_reset_flag_ff)
    else $error("watchdog overflow gave no reset");
  a_rsvd_ones: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    tcs_rd[4:3] == 2'b11 && rcs_rd[5:0] == 6'h3f)
    else $error("reserved bits not one");
  a_standby_clr: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    STANDBY_I && !int_rst |=> !tcs_ff.count_run && tcs_ff.clk_div_sel == $past(tcs_ff.clk_div_sel))
    else $error("standby clearing wrong");
  a_bad_pw: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    req.wr && req.addr == WR_ADDR_TCS && hi != PW_COUNTER && hi != PW_CONTROL
    && !tcs_ff.count_run && !STANDBY_I && !int_rst |=> $stable(tcs_ff.count_run))
    else $error("write without password took effect");
  a_cnt_step: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    step && !wr_cnt && !STANDBY_I |=> wdog_counter_ff == $past(wdog_counter_ff) + 8'h01)
    else $error("counter did not step");
  a_cnt_idle: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    tcs_ff.count_run && !tick && !wr_cnt && !STANDBY_I && !int_rst
    |=> $stable(wdog_counter_ff))
    else $error("counter moved without tick");
  a_counter_load: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wr_cnt && tcs_ff.count_run && !STANDBY_I && !int_rst |=> wdog_counter_ff == $past(lo))
    else $error("counter write lost");
  a_flag_write_one: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wr_tcs && lo[FLAG_BIT] && tcs_ff.overflow_flag && !STANDBY_I && !int_rst
    |=> tcs_ff.overflow_flag)
    else $error("written one cleared flag");
  a_rflag_write_one: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    req.wr && req.addr == WR_ADDR_RCS && hi == PW_CONTROL && lo != 8'h00
    && wdog_reset_flag_ff |=> wdog_reset_flag_ff)
    else $error("reset flag cleared by nonzero write");
  a_rflag_kept: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wdog_reset_flag_ff && !wr_rcs_clr |=> wdog_reset_flag_ff)
    else $error("reset flag lost");
  a_out_en_kept: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !wr_rcs_oe |=> $stable(reset_out_en_ff))
    else $error("output enable changed without write");
  a_div_cleared: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    int_rst |=> tcs_ff.clk_div_sel == 3'h0)
    else $error("divide bits kept through chip reset");
  a_late_overflow: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    overflow |=> !flag_armed_ff)
    else $error("clear still armed after new overflow");
  c_overflow: cover property (@(posedge CLOCK_I) overflow);
  c_irq: cover property (@(posedge CLOCK_I) INTERVAL_IRQ_O);
  c_ext_rst: cover property (@(posedge CLOCK_I) !RESET_OUT_N_O);
  c_flag_clr: cover property (@(posedge CLOCK_I) $fell(tcs_ff.overflow_flag));
endmodule : wdog_unit

// [watchdog_interval_timer_bench.sv]
`timescale 1ns/1ps
module watchdog_interval_timer_bench;
  import wdog_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic standby = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] rdata;
  logic irq, chip_rst, rst_out_n;
  int checked = 0;
  int miscompares = 0;
  int n, n1, n2;
  logic [7:0] v;
  int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

  wdog_unit dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .STANDBY_I(standby), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .INTERVAL_IRQ_O(irq),
    .CHIP_RESET_O(chip_rst), .RESET_OUT_N_O(rst_out_n));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic check_range(input string what, input logic [15:0] lo, input logic [15:0] hi,
                             input logic [15:0] got);
    checked++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      miscompares++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range

  task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_word

  task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_byte

  task automatic rd_check(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_byte(a, d);
    check(what, exp, d);
  endtask : rd_check

  // waits at falling edges until interrupt, or chip reset, is high
  task automatic wait_for(input int lim, input logic on_rst, output int cyc);
    cyc = 0;
    while ((on_rst ? chip_rst : irq) !== 1'b1 && cyc < lim) begin
      @(negedge clk);
      cyc++;
    end
  endtask : wait_for

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    miscompares++;
    $display("watchdog expired before the tests ended");
    end_of_test;
  end

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check("idle outputs", 8'h01, {5'h00, irq, chip_rst, rst_out_n});
    rd_check("control", RD_ADDR_TCS, TCS_RESET);
    rd_check("counter", RD_ADDR_CNT, CNT_RESET);
    rd_check("reset control", RD_ADDR_RCS, RCS_RESET);
    rd_check("unmapped read", 16'hffaa, 8'h00);
    $display("test reset values done");

    wr_word(WR_ADDR_TCS, 16'h1127);
    rd_check("control bad password", RD_ADDR_TCS, 8'h18);
    wr_word(16'hffa9, {PW_CONTROL, 8'h27});
    rd_check("control bad address", RD_ADDR_TCS, 8'h18);
    wr_word(WR_ADDR_TCS, {PW_COUNTER, 8'h3c});
    rd_check("counter held", RD_ADDR_CNT, 8'h00);
    $display("test write protection done");

    wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h20});
    rd_check("control reserved", RD_ADDR_TCS, 8'h38);
    wr_word(WR_ADDR_TCS, {PW_COUNTER, 8'hfd});
    wait_for(40, 1'b0, n);
    check_range("irq delay", 1, 12, n[15:0]);
    check("no chip reset", 8'h00, {7'h00, chip_rst});
    rd_check("flag set", RD_ADDR_TCS, 8'hb8);
    wait_for(600, 1'b0, n);
    check_range("irq period", 500, 512, n[15:0]);
    wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h20});
    rd_check("flag after late overflow", RD_ADDR_TCS, 8'hb8);
    wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h80});
    rd_check("flag kept", RD_ADDR_TCS, 8'h98);
    rd_check("counter stopped", RD_ADDR_CNT, 8'h00);
    wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h00});
    rd_check("flag cleared", RD_ADDR_TCS, 8'h18);
    $display("test interval mode done");

    for (int k = 0; k < 8; k++) begin
      wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h00});
      wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h20 | 8'(k)});
      repeat (4 * divs[k]) @(negedge clk);
      rd_byte(RD_ADDR_CNT, v);
      check_range("counter rate", 3, 5, {8'h00, v});
    end
    $display("test divider codes done");

    wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h65});
    wr_word(WR_ADDR_TCS, {PW_COUNTER, 8'h10});
    @(negedge clk);
    standby = 1'b1;
    @(negedge clk);
    standby = 1'b0;
    rd_check("control standby", RD_ADDR_TCS, 8'h1d);
    rd_check("counter standby", RD_ADDR_CNT, 8'h00);
    $display("test standby done");

    wr_word(WR_ADDR_RCS, {PW_COUNTER, 8'h40});
    rd_check("output enable", RD_ADDR_RCS, 8'h7f);
    wr_word(WR_ADDR_TCS, {PW_CONTROL, 8'h60});
    wr_word(WR_ADDR_TCS, {PW_COUNTER, 8'hfe});
    wait_for(40, 1'b1, n);
    check_range("reset delay", 1, 12, n[15:0]);
    n1 = 0;
    n2 = 0;
    while (chip_rst === 1'b1 && n1 < 700) begin
      n1++;
      if (rst_out_n === 1'b0) begin
        n2++;
      end
      @(negedge clk);
    end
    check_range("internal reset length", 518, 518, n1[15:0]);
    check_range("external reset length", 132, 132, n2[15:0]);
    rd_check("reset flag", RD_ADDR_RCS, 8'hff);
    rd_check("control after reset", RD_ADDR_TCS, 8'h18);
    rd_check("counter after reset", RD_ADDR_CNT, 8'h00);
    wr_word(WR_ADDR_RCS, {PW_CONTROL, 8'h00});
    rd_check("reset flag cleared", RD_ADDR_RCS, 8'h7f);
    wr_word(WR_ADDR_RCS, {PW_COUNTER, 8'h00});
    rd_check("output disabled", RD_ADDR_RCS, 8'h3f);
    $display("test watchdog reset done");

    wr_word(WR_ADDR_RCS, {PW_COUNTER, 8'h40});
    rd_check("output enable again", RD_ADDR_RCS, 8'h7f);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check("outputs after pin reset", 8'h01, {5'h00, irq, chip_rst, rst_out_n});
    rd_check("reset control after pin", RD_ADDR_RCS, RCS_RESET);
    $display("test pin reset done");
    end_of_test;
  end
endmodule : watchdog_interval_timer_bench
